// *** rtl/mlm_core.sv ***
// Summary of operation
// - count load from ram writes chosen limit from data ram, applies both output actions
// - reset bit one restarts the chosen counter from zero, zero keeps its value
// - mode bit zero means direct addressing, one means indexed addressing
// - indexed address is the six-bit field plus the stored base
// - action codes: keep, off, on, toggle the mapped output
// - two-bit select picks limit registers a to d in ascending order
// - count load fields: mode 13, reset 12, actions 11:8, select 7:6, address 5:0
// - immediate high load writes its byte into the upper immediate byte
// - upper clear bit set zeroes the upper immediate byte instead
// - immediate low load writes lower byte, lower clear bit zeroes it
// - jump one load, prefix 1000 and suffix 00, writes ten-bit value
// - jump two load, prefix 1001, same value field, writes jump target b
// - register load copies data ram word at resolved address into a core register
// - register load targets core subset, mode at bit 2, suffix 10
// - multiply result is 32 bits, high register holds upper half
// - multiply takes 17 cycles and reports via operation complete flag
// - multiply updates shift overflow, precision loss and operation complete
// - multiply operands from operand subset, second operand field above first
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "mlm_map.svh"

module mlm_core (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [1:0]       shortcut_out,
   output logic [3:0]       counter_restart,
   output logic [3:0][15:0] count_limit,
   output logic             busy
);

   mlm_pkg::mlm_state_type   state_reg;
   mlm_pkg::mlm_state_type   state_next;
   mlm_pkg::mlm_apb_req_type req;

   logic [15:0] dram [0:63];

   logic        access;
   logic        wr_go;
   logic        rd_go;
   logic        addr_ok;
   logic [31:0] rdata_c;
   logic        instr_go;
   logic [15:0] instr;
   logic        dram_wr;
   logic [5:0]  dram_waddr;
   logic [5:0]  ram_field;
   logic        ram_mode;
   logic [5:0]  ram_addr;
   logic [15:0] ram_word;
   logic        is_cl;
   logic        is_ld;
   logic        is_ja;
   logic        is_jb;
   logic        is_immh;
   logic        is_imml;
   logic        is_mul;
   logic [31:0] addend;

   function automatic logic apply_action(input logic [1:0] act, input logic cur);
      logic res;
      res = cur;
      case (act)
         `MLM_ACT_KEEP:   res = cur;
         `MLM_ACT_OFF:    res = 1'b0;
         `MLM_ACT_ON:     res = 1'b1;
         `MLM_ACT_TOGGLE: res = ~cur;
         default:         res = cur;
      endcase
      return res;
   endfunction

   function automatic logic [15:0] operand(input logic [2:0] sel,
                                           input mlm_pkg::mlm_state_type s);
      logic [15:0] v;
      v = s.gpr[sel];
      // code 7 names the immediate register rather than a general register
      if (sel == 3'h7) begin
         v = s.immediate_value_reg;
      end
      return v;
   endfunction

   assign req.psel    = psel;
   assign req.penable = penable;
   assign req.pwrite  = pwrite;
   assign req.paddr   = paddr;
   assign req.pwdata  = pwdata;

   // one wait state: pready rises one cycle after the access phase opens
   assign access  = req.psel & req.penable & state_reg.rsp.pready;
   // the refusal was latched when pready was raised, so the registered flag decides
   assign wr_go   = access & req.pwrite & ~state_reg.rsp.pslverr;
   assign rd_go   = req.psel & req.penable & ~state_reg.rsp.pready & ~req.pwrite;

   always_comb begin
      addr_ok = 1'b1;
      rdata_c = 32'h0000_0000;
      if (req.paddr[1:0] != 2'h0) begin
         addr_ok = 1'b0;
      end else if (req.paddr >= `MLM_ADDR_DRAM_0) begin
         if (req.paddr[11:8] != 4'h1) begin
            addr_ok = 1'b0;
         end else begin
            rdata_c = {16'h0000, dram[req.paddr[7:2]]};
         end
      end else if (req.paddr >= `MLM_ADDR_GPR_0 && req.paddr < 12'h060) begin
         rdata_c = {16'h0000, state_reg.gpr[req.paddr[4:2]]};
      end else if (req.paddr >= `MLM_ADDR_LIMIT_A && req.paddr < `MLM_ADDR_GPR_0) begin
         rdata_c = {16'h0000, state_reg.count_limit[req.paddr[3:2]]};
      end else begin
         case (req.paddr)
            `MLM_ADDR_INSTR:   rdata_c = {16'h0000, state_reg.instr_last};
            `MLM_ADDR_STATUS:  rdata_c = {28'h000_0000,
                                         state_reg.phase != mlm_pkg::MLM_IDLE,
                                         state_reg.flags};
            `MLM_ADDR_IMM:     rdata_c = {16'h0000, state_reg.immediate_value_reg};
            `MLM_ADDR_JUMP_A:  rdata_c = {16'h0000, state_reg.jump_target_a};
            `MLM_ADDR_JUMP_B:  rdata_c = {16'h0000, state_reg.jump_target_b};
            `MLM_ADDR_PROD_HI: rdata_c = {16'h0000, state_reg.product_high};
            `MLM_ADDR_PROD_LO: rdata_c = {16'h0000, state_reg.product_low};
            `MLM_ADDR_BASE:    rdata_c = {26'h000_0000, state_reg.base};
            `MLM_ADDR_OUTPUTS: rdata_c = {30'h0000_0000, state_reg.out_state};
            default:           addr_ok = 1'b0;
         endcase
      end
   end

   // instruction issue; refused while the multiplier is still running
   assign instr    = req.pwdata[15:0];
   assign instr_go = wr_go & (req.paddr == `MLM_ADDR_INSTR);

   // decode on fixed prefix bits, plus suffix bits 1:0 for all but count load and multiply
   assign is_cl   = instr[15:14] == `MLM_OP_CL_PFX;
   assign is_ld   = instr[15:14] == `MLM_OP_LD_PFX && instr[1:0] == `MLM_OP_LD_SFX;
   assign is_ja   = instr[15:12] == `MLM_OP_JA_PFX && instr[1:0] == `MLM_OP_JMP_SFX;
   assign is_jb   = instr[15:12] == `MLM_OP_JB_PFX && instr[1:0] == `MLM_OP_JMP_SFX;
   assign is_immh = instr[15:11] == `MLM_OP_IMM_PFX && instr[1:0] == `MLM_OP_IMMH_SFX;
   assign is_imml = instr[15:11] == `MLM_OP_IMM_PFX && instr[1:0] == `MLM_OP_IMML_SFX;
   assign is_mul  = instr[15:6] == `MLM_OP_MUL_PFX;

   // data ram address: the two instructions keep field and mode in different places
   always_comb begin
      ram_field = instr[`MLM_RAM_ADDR_HI:0];
      ram_mode  = instr[`MLM_CL_MODE_BIT];
      if (is_ld) begin
         ram_field = instr[`MLM_LD_ADDR_HI:`MLM_LD_ADDR_LO];
         ram_mode  = instr[`MLM_LD_MODE_BIT];
      end
      ram_addr = ram_field;
      if (ram_mode) begin
         // wraps inside the 64-word ram; no fault for a base past the end
         ram_addr = ram_field + state_reg.base;
      end
   end
   assign ram_word = dram[ram_addr];

   assign dram_wr    = wr_go && req.paddr[11:8] == 4'h1;
   assign dram_waddr = req.paddr[7:2];

   always_ff @(posedge clk) begin
      if (dram_wr) begin
         dram[dram_waddr] <= req.pwdata[15:0];
      end
   end

   assign addend = state_reg.mul_b[state_reg.step[3:0]] ?
                   ({16'h0000, state_reg.mul_a} << state_reg.step[3:0]) : 32'h0000_0000;

   always_comb begin
      state_next = state_reg;
      state_next.counter_restart = 4'h0;

      // apb answer
      state_next.rsp.pready = req.psel & req.penable & ~state_reg.rsp.pready;
      if (state_next.rsp.pready) begin
         state_next.rsp.pslverr = ~addr_ok;
         if (req.pwrite && req.paddr == `MLM_ADDR_INSTR &&
             state_reg.phase != mlm_pkg::MLM_IDLE) begin
            state_next.rsp.pslverr = 1'b1;
         end
      end else begin
         state_next.rsp.pslverr = 1'b0;
      end
      if (rd_go) begin
         state_next.rsp.prdata = rdata_c;
      end

      // software writes to plain registers
      if (wr_go) begin
         if (req.paddr >= `MLM_ADDR_GPR_0 && req.paddr < 12'h060) begin
            state_next.gpr[req.paddr[4:2]] = req.pwdata[15:0];
         end else if (req.paddr >= `MLM_ADDR_LIMIT_A && req.paddr < `MLM_ADDR_GPR_0) begin
            state_next.count_limit[req.paddr[3:2]] = req.pwdata[15:0];
         end else begin
            case (req.paddr)
               `MLM_ADDR_IMM:    state_next.immediate_value_reg = req.pwdata[15:0];
               `MLM_ADDR_JUMP_A: state_next.jump_target_a = req.pwdata[15:0];
               `MLM_ADDR_JUMP_B: state_next.jump_target_b = req.pwdata[15:0];
               `MLM_ADDR_BASE:   state_next.base = req.pwdata[5:0];
               default:          state_next.base = state_next.base;
            endcase
         end
      end

      // instruction execution
      if (instr_go) begin
         state_next.instr_last = instr;
         if (is_cl) begin
            state_next.count_limit[instr[`MLM_CL_SEL_HI -: 2]] = ram_word;
            if (instr[`MLM_CL_RST_BIT]) begin
               state_next.counter_restart[instr[`MLM_CL_SEL_HI -: 2]] = 1'b1;
            end
            state_next.out_state[0] = apply_action(instr[`MLM_CL_ACT1_HI -: 2],
                                                   state_reg.out_state[0]);
            state_next.out_state[1] = apply_action(instr[`MLM_CL_ACT2_HI -: 2],
                                                   state_reg.out_state[1]);
         end else if (is_ld) begin
            state_next.gpr[instr[5:3]] = ram_word;
         end else if (is_ja) begin
            state_next.jump_target_a = {6'h00, instr[`MLM_JMP_VAL_HI:`MLM_JMP_VAL_LO]};
         end else if (is_jb) begin
            state_next.jump_target_b = {6'h00, instr[`MLM_JMP_VAL_HI:`MLM_JMP_VAL_LO]};
         end else if (is_immh) begin
            if (instr[`MLM_IMM_CLR_BIT]) begin
               state_next.immediate_value_reg[15:8] = 8'h00;
            end else begin
               state_next.immediate_value_reg[15:8] =
                  instr[`MLM_IMM_VAL_HI:`MLM_IMM_VAL_LO];
            end
         end else if (is_imml) begin
            if (instr[`MLM_IMM_CLR_BIT]) begin
               state_next.immediate_value_reg[7:0] = 8'h00;
            end else begin
               state_next.immediate_value_reg[7:0] =
                  instr[`MLM_IMM_VAL_HI:`MLM_IMM_VAL_LO];
            end
         end else if (is_mul) begin
            state_next.mul_a = operand(instr[2:0], state_reg);
            state_next.mul_b = operand(instr[5:3], state_reg);
            state_next.acc   = 32'h0000_0000;
            state_next.step  = 5'h00;
            state_next.flags = '0;
            state_next.phase = mlm_pkg::MLM_RUN;
         end
      end

      // sixteen shift-add steps plus a closing cycle give the documented latency
      case (state_reg.phase)
         mlm_pkg::MLM_IDLE: begin
            state_next.step = state_next.step;
         end
         mlm_pkg::MLM_RUN: begin
            state_next.acc  = state_reg.acc + addend;
            state_next.step = state_reg.step + 5'h01;
            if (state_reg.step == `MLM_MUL_STEPS - 5'h01) begin
               state_next.phase = mlm_pkg::MLM_DONE;
            end
         end
         mlm_pkg::MLM_DONE: begin
            state_next.product_high = state_reg.acc[31:16];
            state_next.product_low  = state_reg.acc[15:0];
            // no shift happens here, so overflow and loss stay clear
            state_next.flags.shift_overflow_flag = 1'b0;
            state_next.flags.precision_loss_flag = 1'b0;
            state_next.flags.op_complete_flag    = 1'b1;
            state_next.phase = mlm_pkg::MLM_IDLE;
         end
         default: begin
            state_next.phase = mlm_pkg::MLM_IDLE;
         end
      endcase

      if (rst) begin
         state_next = '0;
         state_next.phase = mlm_pkg::MLM_IDLE;
         state_next.base  = `MLM_RST_BASE;
      end
   end

   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   assign prdata          = state_reg.rsp.prdata;
   assign pready          = state_reg.rsp.pready;
   assign pslverr         = state_reg.rsp.pslverr;
   assign shortcut_out    = state_reg.out_state;
   assign counter_restart = state_reg.counter_restart;
   assign count_limit     = state_reg.count_limit;
   assign busy            = state_reg.phase != mlm_pkg::MLM_IDLE;

endmodule

// *** rtl/mlm_map.svh ***
`ifndef MLM_MAP_SVH
`define MLM_MAP_SVH

// apb byte addresses
`define MLM_ADDR_INSTR      12'h000
`define MLM_ADDR_STATUS     12'h004
`define MLM_ADDR_IMM        12'h008
`define MLM_ADDR_JUMP_A     12'h00C
`define MLM_ADDR_JUMP_B     12'h010
`define MLM_ADDR_PROD_HI    12'h014
`define MLM_ADDR_PROD_LO    12'h018
`define MLM_ADDR_BASE       12'h01C
`define MLM_ADDR_OUTPUTS    12'h020
`define MLM_ADDR_LIMIT_A    12'h030
`define MLM_ADDR_GPR_0      12'h040
`define MLM_ADDR_DRAM_0     12'h100

// instruction fields
`define MLM_CL_MODE_BIT     13
`define MLM_CL_RST_BIT      12
`define MLM_CL_ACT1_HI      11
`define MLM_CL_ACT2_HI      9
`define MLM_CL_SEL_HI       7
`define MLM_RAM_ADDR_HI     5
`define MLM_LD_ADDR_HI      13
`define MLM_LD_ADDR_LO      8
`define MLM_LD_MODE_BIT     2
`define MLM_IMM_CLR_BIT     10
`define MLM_IMM_VAL_HI      9
`define MLM_IMM_VAL_LO      2
`define MLM_JMP_VAL_HI      11
`define MLM_JMP_VAL_LO      2

// opcode prefixes
`define MLM_OP_CL_PFX       2'h1
`define MLM_OP_LD_PFX       2'h2
`define MLM_OP_LD_SFX       2'h2
`define MLM_OP_JA_PFX       4'h8
`define MLM_OP_JB_PFX       4'h9
`define MLM_OP_JMP_SFX      2'h0
`define MLM_OP_IMM_PFX      5'h07
`define MLM_OP_IMMH_SFX     2'h1
`define MLM_OP_IMML_SFX     2'h2
`define MLM_OP_MUL_PFX      10'h0B6

// output action codes
`define MLM_ACT_KEEP        2'h0
`define MLM_ACT_OFF         2'h1
`define MLM_ACT_ON          2'h2
`define MLM_ACT_TOGGLE      2'h3

// multiply timing
`define MLM_MUL_CYCLES      17
`define MLM_MUL_STEPS       5'h10

// reset values
`define MLM_RST_WORD        16'h0000
`define MLM_RST_BASE        6'h00

`endif

// *** rtl/mlm_pkg.sv ***
package mlm_pkg;

   typedef enum logic [1:0] {
      MLM_IDLE = 2'h0,
      MLM_RUN  = 2'h1,
      MLM_DONE = 2'h3
   } mlm_phase_type;

   typedef struct packed {
      logic        shift_overflow_flag;
      logic        precision_loss_flag;
      logic        op_complete_flag;
   } mlm_flags_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } mlm_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } mlm_apb_rsp_type;

   typedef struct packed {
      mlm_phase_type        phase;
      logic [15:0]          instr_last;
      logic [15:0]          immediate_value_reg;
      logic [15:0]          jump_target_a;
      logic [15:0]          jump_target_b;
      logic [15:0]          product_high;
      logic [15:0]          product_low;
      logic [5:0]           base;
      logic [3:0][15:0]     count_limit;
      logic [7:0][15:0]     gpr;
      logic [1:0]           out_state;
      logic [3:0]           counter_restart;
      mlm_flags_type        flags;
      logic [15:0]          mul_a;
      logic [15:0]          mul_b;
      logic [31:0]          acc;
      logic [4:0]           step;
      mlm_apb_rsp_type      rsp;
   } mlm_state_type;

endpackage

// *** sim/mlm_check_properties.sv ***
`timescale 1ns/10ps
`include "mlm_map.svh"

module mlm_check (
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic [1:0]      shortcut_out,
   input wire logic [3:0]      counter_restart,
   input wire logic [3:0][15:0] count_limit,
   input wire logic            busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   wire acc_w = psel && penable && pready && pwrite;
   wire ins_w = acc_w && paddr == `MLM_ADDR_INSTR && !pslverr;
   wire cl_w  = ins_w && pwdata[15:14] == `MLM_OP_CL_PFX;
   wire mul_w = ins_w && pwdata[15:6] == `MLM_OP_MUL_PFX;

   function automatic logic act(input logic c, input logic [1:0] k);
      return k == `MLM_ACT_KEEP ? c : k == `MLM_ACT_TOGGLE ? !c : k == `MLM_ACT_ON;
   endfunction

   sequence s_access_start;
      psel && penable && !$past(penable);
   endsequence
   // busy seen on 17 edges after the issuing edge, then low
   sequence s_run17;
      busy [*8] ##1 busy [*8] ##1 busy ##1 !busy;
   endsequence

   a_ready_wait: assert property (s_access_start |-> !pready ##1 pready)
      else $error("pready not one cycle after access start");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_restart_sel: assert property (cl_w |=> counter_restart ==
      ($past(pwdata[12]) ? 4'h1 << $past(pwdata[7:6]) : 4'h0))
      else $error("counter restart pulse wrong");
   a_out_first: assert property (cl_w |=> shortcut_out[0] ==
      act($past(shortcut_out[0]), $past(pwdata[11:10])))
      else $error("first output action wrong");
   a_out_second: assert property (cl_w |=> shortcut_out[1] ==
      act($past(shortcut_out[1]), $past(pwdata[9:8])))
      else $error("second output action wrong");
   a_out_hold: assert property (!cl_w |=> $stable(shortcut_out))
      else $error("outputs moved without count load");
   a_limit_hold: assert property (!acc_w |=> $stable(count_limit))
      else $error("limit moved without a write");
   a_mul_len: assert property (mul_w |=> s_run17)
      else $error("multiply length wrong");
   a_mul_cause: assert property ($rose(busy) |-> $past(mul_w))
      else $error("busy without multiply issue");
   a_busy_refuse: assert property (busy && acc_w && paddr == `MLM_ADDR_INSTR |-> pslverr)
      else $error("instruction accepted while busy");
endmodule

bind mlm_core mlm_check chk (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .shortcut_out(shortcut_out), .counter_restart(counter_restart),
   .count_limit(count_limit), .busy(busy)
);

// *** sim/mlm_apb_host.sv ***
`timescale 1ns/10ps

module mlm_apb_host (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        go,
   input  wire logic        wr,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        pready,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic             done
);
   // request held until pready is sampled; a released bus is inverted so no stale value looks valid
   always @(posedge clk) begin
      done <= 1'b0;
      if (rst) begin
         psel <= 1'b0;
         penable <= 1'b0;
         pwrite <= 1'b0;
         paddr <= 12'h000;
         pwdata <= 32'h0000_0000;
      end else if (psel && penable && pready) begin
         psel <= 1'b0;
         penable <= 1'b0;
         pwrite <= ~pwrite;
         paddr <= ~paddr;
         pwdata <= ~pwdata;
         done <= 1'b1;
      end else if (psel) begin
         penable <= 1'b1;
      end else if (go) begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= addr;
         pwdata <= wdata;
      end
   end
endmodule

// *** sim/microcore_load_mul_instrs_bench.sv ***
`timescale 1ns/10ps
`include "mlm_map.svh"

module microcore_load_mul_instrs_bench;
   logic             clk, rst, go, wr, psel, penable, pwrite, pready, pslverr, done, busy;
   logic [11:0]      addr, paddr;
   logic [31:0]      wdata, pwdata, prdata, r, p, seed;
   logic [1:0]       shortcut_out, outs;
   logic [3:0]       counter_restart;
   logic [3:0][15:0] count_limit;
   logic [17:0]      exp_q[$];
   logic [17:0]      n;
   logic [15:0]      ram[64];
   logic [15:0]      gpr[8];
   logic [15:0]      imm, ins;
   logic [5:0]       base, a;
   int               fail_count, cmp_count, cyc;
   localparam logic [11:0] ZR[7] = '{`MLM_ADDR_STATUS, `MLM_ADDR_IMM, `MLM_ADDR_JUMP_A,
      `MLM_ADDR_JUMP_B, `MLM_ADDR_PROD_HI, `MLM_ADDR_OUTPUTS, `MLM_ADDR_LIMIT_A};

   mlm_core uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .shortcut_out(shortcut_out), .counter_restart(counter_restart),
      .count_limit(count_limit), .busy(busy));
   mlm_apb_host host (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
      .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .done(done));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic act(input logic c, input logic [1:0] k);
      return k == `MLM_ACT_KEEP ? c : k == `MLM_ACT_TOGGLE ? !c : k == `MLM_ACT_ON;
   endfunction
   function automatic logic [15:0] opv(input logic [2:0] c);
      return c == 3'h7 ? imm : gpr[c];
   endfunction

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // e and x: expected error flag and read data; data is ignored on writes
   task automatic xfer(input logic w, input logic [11:0] ad, input logic [15:0] d,
                       input logic e, input logic [15:0] x);
      exp_q.push_back({~w, e, x});
      go <= 1'b1;
      wr <= w;
      addr <= ad;
      wdata <= {16'h0000, d};
      @(posedge clk);
      go <= 1'b0;
      // no fixed wait is assumed; only the cycle ceiling ends a stuck transfer
      while (done !== 1'b1) @(posedge clk);
   endtask
   task automatic wt(input logic [11:0] ad, input logic [15:0] d);
      xfer(1'b1, ad, d, 1'b0, 16'h0000);
   endtask
   task automatic rd(input logic [11:0] ad, input logic [15:0] x);
      xfer(1'b0, ad, 16'h0000, 1'b0, x);
   endtask

   always @(posedge clk) begin
      if (psel && penable && pready) begin
         n = exp_q.pop_front();
         cmp_count++;
         if (pslverr !== n[16] || (n[17] && prdata !== {16'h0000, n[15:0]})) begin
            fail_count++;
            $display("wrong value at %0t: got %h %h, want %h", $time, pslverr, prdata, n);
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      go = 1'b0;
      wr = 1'b0;
      addr = 12'h000;
      wdata = 32'h0000_0000;
      seed = 32'h0000_0045;
      outs = 2'h0;
      imm = 16'h0000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (ZR[i]) rd(ZR[i], 16'h0000);
      xfer(1'b0, 12'h002, 16'h0000, 1'b1, 16'h0000);
      xfer(1'b1, 12'h028, 16'h1234, 1'b1, 16'h0000);
      xfer(1'b0, 12'h028, 16'h0000, 1'b1, 16'h0000);
      for (int i = 0; i < 64; i++) begin
         ram[i] = 16'(xs());
         wt(`MLM_ADDR_DRAM_0 | 12'(i * 4), ram[i]);
      end
      // every select, action pair, mode and restart value across the sixteen passes
      for (int i = 0; i < 16; i++) begin
         r = xs();
         base = r[21:16];
         wt(`MLM_ADDR_BASE, {10'h000, base});
         ins = {2'b01, i[2], i[3], i[1:0], i[3:2], i[1:0], r[5:0]};
         a = ins[13] ? base + ins[5:0] : ins[5:0];
         outs[0] = act(outs[0], ins[11:10]);
         outs[1] = act(outs[1], ins[9:8]);
         wt(`MLM_ADDR_INSTR, ins);
         rd(`MLM_ADDR_LIMIT_A | {ins[7:6], 2'b00}, ram[a]);
         rd(`MLM_ADDR_OUTPUTS, {14'h0000, outs});
      end
      // clears first, loads last, so the immediate ends up non-zero for the multiply
      for (int i = 3; i >= 0; i--) begin
         r = xs();
         ins = {5'b00111, i[1], r[7:0], ~i[0], i[0]};
         // suffix 01 loads the upper byte, suffix 10 the lower byte
         if (i[0])
            imm[15:8] = i[1] ? 8'h00 : r[7:0];
         else
            imm[7:0] = i[1] ? 8'h00 : r[7:0];
         wt(`MLM_ADDR_INSTR, ins);
         rd(`MLM_ADDR_IMM, imm);
      end
      for (int i = 0; i < 2; i++) begin
         r = xs();
         wt(`MLM_ADDR_INSTR, {3'b100, i[0], r[9:0], 2'b00});
         rd(i ? `MLM_ADDR_JUMP_B : `MLM_ADDR_JUMP_A, {6'h00, r[9:0]});
      end
      for (int i = 0; i < 8; i++) begin
         r = xs();
         ins = {2'b10, r[5:0], r[7:6], i[2:0], i[0], 2'b10};
         a = ins[2] ? base + ins[13:8] : ins[13:8];
         gpr[i] = ram[a];
         wt(`MLM_ADDR_INSTR, ins);
         rd(`MLM_ADDR_GPR_0 | {i[2:0], 2'b00}, gpr[i]);
      end
      for (int i = 0; i < 4; i++) begin
         r = xs();
         ins = {`MLM_OP_MUL_PFX, i == 0 ? 6'h3F : r[5:0]};
         p = opv(ins[2:0]) * opv(ins[5:3]);
         wt(`MLM_ADDR_INSTR, ins);
         xfer(1'b1, `MLM_ADDR_INSTR, 16'h0000, 1'b1, 16'h0000);
         while (busy !== 1'b0) @(posedge clk);
         rd(`MLM_ADDR_PROD_HI, p[31:16]);
         rd(`MLM_ADDR_PROD_LO, p[15:0]);
         rd(`MLM_ADDR_STATUS, 16'h0001);
         rd(`MLM_ADDR_INSTR, ins);
      end
      wt(`MLM_ADDR_PROD_HI, 16'hFFFF);
      rd(`MLM_ADDR_PROD_HI, p[31:16]);
      close_out();
   end
endmodule
